//--- rtl/acf_control.sv
// Converter clock, range and filter path control with APB register access
`timescale 1ns/1ps
module acf_control #(
    parameter int BIQUADS = 4,
    parameter int DEPTH   = acf_pkg::COEF_DEPTH,
    parameter int CWIDTH  = acf_pkg::COEF_WIDTH
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                ext_clk_pin,
    input  wire logic                int_osc_clk,
    input  wire logic                start_pin,
    input  wire logic                reset_n_pin,
    input  wire logic                mod_saturated,
    output logic                     sys_clk_en,
    output logic                     mod_clk_en,
    output logic                     data_ready,
    output logic                     wide_input_range,
    output acf_pkg::acf_path_t       path_cfg,
    output logic [15:0]              osr_active,
    output logic                     pins_blanked
);
    import acf_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers: three stages, change taken when last two agree
    // ------------------------------------------------------------------
    localparam int NPIN = 4;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin_level;
    logic [NPIN-1:0] next_pin_level;
    logic [NPIN-1:0] pin_rise;

    assign pin_raw = {reset_n_pin, start_pin, int_osc_clk, ext_clk_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= PIN_IDLE[gi];
                    sync2[gi] <= PIN_IDLE[gi];
                    sync3[gi] <= PIN_IDLE[gi];
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
            always_comb begin
                next_pin_level[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : pin_level[gi];
                pin_rise[gi]       = next_pin_level[gi] & ~pin_level[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [1:0]        cfg_one;
    logic [3:0]        cfg_three;
    logic [10:0]       filt_cfg;
    logic [4:0]        coef_addr;
    logic [CWIDTH-1:0] coef_mem [DEPTH];
    logic [11:0]       blank_cnt;
    logic              sat_accum;
    logic              sat_flag;
    logic [15:0]       conv_cnt;
    logic [1:0]        next_cfg_one;
    logic [3:0]        next_cfg_three;
    logic [10:0]       next_filt_cfg;
    logic [4:0]        next_coef_addr;
    logic [11:0]       next_blank_cnt;
    logic              next_sat_accum;
    logic              next_sat_flag;
    logic [15:0]       next_conv_cnt;
    logic              next_data_ready;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              wr_en;
    logic              dev_reset;
    logic              running;
    logic [15:0]       osr_now;
    acf_path_t         next_path;
    acf_ticks_t        ticks;

    // Low-latency ratio for a speed mode and sinc code
    function automatic logic [15:0] ll_osr(input logic [1:0] speed, input logic [2:0] code);
        logic [15:0] base;
        base = LL_BASE_MID;
        unique case (acf_speed_t'(speed))
            SPEED_MAX:  base = LL_BASE_MAX;
            SPEED_HIGH: base = LL_BASE_HIGH;
            SPEED_MID:  base = LL_BASE_MID;
            SPEED_LOW:  base = LL_BASE_LOW;
        endcase
        return 16'(base << code);
    endfunction : ll_osr

    // Address decode, used by both read and write paths
    function automatic logic addr_known(input logic [7:0] a);
        return (a == ADDR_CONFIG_ONE) || (a == ADDR_CONFIG_THREE) ||
               (a == ADDR_FILTER_CFG) || (a == ADDR_STATUS_ONE) ||
               (a == ADDR_COEF_ADDR) || (a == ADDR_COEF_DATA);
    endfunction : addr_known

    // ------------------------------------------------------------------
    // Clock chain
    // ------------------------------------------------------------------
    acf_clock_chain i_acf_clock_chain (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_sel  (cfg_three[C3_CLK_SEL]),
        .div_code (cfg_three[C3_DIV_LSB +: 3]),
        .int_edge (pin_rise[1]),
        .ext_edge (pin_rise[0]),
        .ticks    (ticks)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        wr_en     = psel & penable & pready & pwrite;
        // Start and reset pins are honoured only outside the blanking window
        dev_reset = (blank_cnt == '0) & ~pin_level[3];
        running   = (blank_cnt == '0) & pin_level[2];

        // Decimation chain: sinc, then FIRST_FIR_STAGE by two, SECOND_FIR_STAGE and THIRD_FIR_STAGE by two
        if (filt_cfg[FC_LOW_LAT]) begin
            if (cfg_three[C3_DIV_LSB +: 3] == DIV_BY_2 ||
                cfg_three[C3_DIV_LSB +: 3] == DIV_BY_16) begin
                osr_now = ll_osr(SPEED_MID, filt_cfg[FC_OSR_LSB +: 3]);
            end else begin
                osr_now = ll_osr(filt_cfg[FC_SPEED_LSB +: 2], filt_cfg[FC_OSR_LSB +: 3]);
            end
        end else begin
            osr_now = 16'((SINC_OSR_MIN << filt_cfg[FC_OSR_LSB +: 3]) << 1);
            // IIR does no decimation; bypassed FIR stages drop theirs
            if (filt_cfg[FC_SECOND_FIR_STAGE_EN]) osr_now = 16'(osr_now << 1);
            if (filt_cfg[FC_THIRD_FIR_STAGE_EN]) osr_now = 16'(osr_now << 1);
        end

        next_cfg_one   = cfg_one;
        next_cfg_three = cfg_three;
        next_filt_cfg  = filt_cfg;
        next_coef_addr = coef_addr;
        next_blank_cnt = (blank_cnt != '0) ? blank_cnt - 12'd1 : blank_cnt;

        if (wr_en) begin
            unique case (paddr)
                ADDR_CONFIG_ONE:   next_cfg_one  = pwdata[1:0];
                ADDR_CONFIG_THREE: begin
                    next_cfg_three = pwdata[3:0];
                    if (pwdata[C3_CLK_SEL] != cfg_three[C3_CLK_SEL]) begin
                        next_blank_cnt = BLANK_CYCLES;
                    end
                end
                ADDR_FILTER_CFG:   next_filt_cfg  = pwdata[10:0];
                ADDR_COEF_ADDR:    next_coef_addr = pwdata[4:0];
                default:           ;
            endcase
        end
        if (dev_reset) begin
            next_cfg_one   = RST_CONFIG_ONE;
            next_cfg_three = RST_CONFIG_THREE;
            next_filt_cfg  = RST_FILTER_CFG;
        end

        // Conversion timing and saturation capture
        next_conv_cnt   = conv_cnt;
        next_sat_accum  = sat_accum | mod_saturated;
        next_sat_flag   = sat_flag;
        next_data_ready = 1'b0;
        if (!running) begin
            next_conv_cnt = '0;
        end else if (ticks.mod_tick) begin
            if (conv_cnt >= osr_now - 16'd1) begin
                next_conv_cnt   = '0;
                next_data_ready = 1'b1;
                next_sat_flag   = sat_accum | mod_saturated;
                // New period starts clean; this cycle already went above
                next_sat_accum  = 1'b0;
            end else begin
                next_conv_cnt = conv_cnt + 16'd1;
            end
        end

        // Path configuration seen by the filter datapath
        next_path.low_latency     = filt_cfg[FC_LOW_LAT];
        next_path.second_fir_stage_en         = filt_cfg[FC_SECOND_FIR_STAGE_EN];
        next_path.third_fir_stage_en         = filt_cfg[FC_THIRD_FIR_STAGE_EN];
        next_path.iir_en          = filt_cfg[FC_IIR_EN];
        next_path.iir_before_third_fir_stage = filt_cfg[FC_SWAP];
        next_path.user_coef       = filt_cfg[FC_USER_COEF];

        // Register answer one cycle into the access phase
        next_pready  = psel & penable & ~pready;
        next_pslverr = 1'b0;
        next_prdata  = '0;
        if (psel & penable & ~pready) begin
            next_pslverr = ~addr_known(paddr);
            if (!pwrite) begin
                unique case (paddr)
                    ADDR_CONFIG_ONE:   next_prdata = {30'h0000_0000, cfg_one};
                    ADDR_CONFIG_THREE: next_prdata = {28'h000_0000, cfg_three};
                    ADDR_FILTER_CFG:   next_prdata = {21'h00_0000, filt_cfg};
                    ADDR_STATUS_ONE:   next_prdata = {28'h000_0000, running,
                                                      blank_cnt != '0, wide_input_range,
                                                      sat_flag};
                    ADDR_COEF_ADDR:    next_prdata = {27'h000_0000, coef_addr};
                    ADDR_COEF_DATA:    next_prdata = 32'(coef_mem[coef_addr]);
                    default:           next_prdata = '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered state
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level        <= PIN_IDLE;
            cfg_one          <= RST_CONFIG_ONE;
            cfg_three        <= RST_CONFIG_THREE;
            filt_cfg         <= RST_FILTER_CFG;
            coef_addr        <= '0;
            blank_cnt        <= '0;
            sat_accum        <= 1'b0;
            sat_flag         <= 1'b0;
            conv_cnt         <= '0;
            data_ready       <= 1'b0;
            prdata           <= '0;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            sys_clk_en       <= 1'b0;
            mod_clk_en       <= 1'b0;
            wide_input_range <= 1'b0;
            path_cfg         <= '0;
            osr_active       <= '0;
            pins_blanked     <= 1'b0;
        end else begin
            pin_level        <= next_pin_level;
            cfg_one          <= next_cfg_one;
            cfg_three        <= next_cfg_three;
            filt_cfg         <= next_filt_cfg;
            coef_addr        <= next_coef_addr;
            blank_cnt        <= next_blank_cnt;
            sat_accum        <= next_sat_accum;
            sat_flag         <= next_sat_flag;
            conv_cnt         <= next_conv_cnt;
            data_ready       <= next_data_ready;
            prdata           <= next_prdata;
            pready           <= next_pready;
            pslverr          <= next_pslverr;
            sys_clk_en       <= ticks.sys_tick;
            mod_clk_en       <= ticks.mod_tick;
            // High reference range overrides the input range bit
            wide_input_range <= cfg_one[C1_INPUT_RANGE] &
                                ~cfg_one[C1_REF_RANGE];
            path_cfg         <= next_path;
            osr_active       <= osr_now;
            pins_blanked     <= (next_blank_cnt != '0);
        end
    end

    // Coefficient store: no reset, so it maps onto plain memory
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == ADDR_COEF_DATA) begin
            coef_mem[coef_addr] <= pwdata[CWIDTH-1:0];
        end
    end

endmodule : acf_control

//--- rtl/acf_pkg.sv
// Package for the converter clock and filter path control block
package acf_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG_ONE   = 8'h00;
    localparam logic [7:0] ADDR_CONFIG_THREE = 8'h04;
    localparam logic [7:0] ADDR_FILTER_CFG   = 8'h08;
    localparam logic [7:0] ADDR_STATUS_ONE   = 8'h0C;
    localparam logic [7:0] ADDR_COEF_ADDR    = 8'h10;
    localparam logic [7:0] ADDR_COEF_DATA    = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int C1_INPUT_RANGE = 0;
    localparam int C1_REF_RANGE   = 1;
    localparam int C3_CLK_SEL     = 0;
    localparam int C3_DIV_LSB     = 1;
    localparam int FC_LOW_LAT     = 0;
    localparam int FC_OSR_LSB     = 1;
    localparam int FC_SECOND_FIR_STAGE_EN     = 4;
    localparam int FC_THIRD_FIR_STAGE_EN     = 5;
    localparam int FC_IIR_EN      = 6;
    localparam int FC_SWAP        = 7;
    localparam int FC_USER_COEF   = 8;
    localparam int FC_SPEED_LSB   = 9;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  RST_CONFIG_ONE   = 2'b00;
    localparam logic [3:0]  RST_CONFIG_THREE = 4'h0;
    localparam logic [10:0] RST_FILTER_CFG   = 11'h070;
    localparam logic [3:0]  PIN_IDLE         = 4'h8;

    // ------------------------------------------------------------------
    // Clock divider codes: ratio is two to the power of the code
    // ------------------------------------------------------------------
    localparam logic [2:0] DIV_BY_2  = 3'd1;
    localparam logic [2:0] DIV_BY_16 = 3'd4;

    // ------------------------------------------------------------------
    // Oversampling ratio bases
    // ------------------------------------------------------------------
    localparam logic [15:0] SINC_OSR_MIN   = 16'h0004;
    localparam logic [15:0] LL_BASE_MAX    = 16'h000C;
    localparam logic [15:0] LL_BASE_HIGH   = 16'h000C;
    localparam logic [15:0] LL_BASE_MID    = 16'h000C;
    localparam logic [15:0] LL_BASE_LOW    = 16'h000C;

    // ------------------------------------------------------------------
    // Control pin blanking after a clock mode change
    // ------------------------------------------------------------------
    localparam int          PCLK_HZ        = 10_000_000;
    localparam int          BLANK_TIME_US  = 150;
    localparam int          BLANK_CYCLES_I = (BLANK_TIME_US * (PCLK_HZ / 1_000_000));
    localparam logic [11:0] BLANK_CYCLES   = 12'(BLANK_CYCLES_I);

    // Coefficient store: four biquads of five words plus FIR words
    localparam int COEF_DEPTH = 32;
    localparam int COEF_WIDTH = 24;

    typedef enum logic [1:0] {
        SPEED_MAX  = 2'b00,
        SPEED_HIGH = 2'b01,
        SPEED_MID  = 2'b10,
        SPEED_LOW  = 2'b11
    } acf_speed_t;

    typedef struct packed {
        logic       low_latency;
        logic       second_fir_stage_en;
        logic       third_fir_stage_en;
        logic       iir_en;
        logic       iir_before_third_fir_stage;
        logic       user_coef;
    } acf_path_t;

    typedef struct packed {
        logic       sys_tick;
        logic       mod_tick;
    } acf_ticks_t;

endpackage : acf_pkg

//--- rtl/acf_clock_chain.sv
// Clock source selection, system clock divider and modulator halving
`timescale 1ns/1ps
module acf_clock_chain (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clk_sel,
    input  wire logic [2:0]          div_code,
    input  wire logic                int_edge,
    input  wire logic                ext_edge,
    output acf_pkg::acf_ticks_t      ticks
);
    import acf_pkg::*;

    logic [6:0] div_cnt;
    logic [6:0] next_div_cnt;
    logic       mod_phase;
    logic       next_mod_phase;
    acf_ticks_t next_ticks;
    logic       src_edge;
    logic [6:0] div_last;

    always_comb begin
        src_edge       = clk_sel ? ext_edge : int_edge;
        div_last       = 7'((8'h01 << div_code) - 8'h01);
        next_div_cnt   = div_cnt;
        next_mod_phase = mod_phase;
        next_ticks     = '0;
        if (src_edge) begin
            if (div_cnt >= div_last) begin
                next_div_cnt        = '0;
                next_ticks.sys_tick = 1'b1;
                next_mod_phase      = ~mod_phase;
                next_ticks.mod_tick = mod_phase;
            end else begin
                next_div_cnt = div_cnt + 7'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt   <= '0;
            mod_phase <= 1'b0;
            ticks     <= '0;
        end else begin
            div_cnt   <= next_div_cnt;
            mod_phase <= next_mod_phase;
            ticks     <= next_ticks;
        end
    end

endmodule : acf_clock_chain

//--- tb/acf_clk_src.sv
// Clock source model: free internal oscillator and gated external clock
`timescale 1ns/1ps
module acf_clk_src (
    input  wire logic ext_run,
    output logic      ext_clk_pin,
    output logic      int_osc_clk
);
    // Ten pclk periods, well below the pclk/6 limit of the pin sampler
    initial begin
        int_osc_clk = 1'b0;
        forever #500 int_osc_clk = ~int_osc_clk;
    end
    // External clock stands low whenever the host has it stopped
    initial begin
        ext_clk_pin = 1'b0;
        forever begin
            #400;
            ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;
        end
    end
endmodule : acf_clk_src

//--- tb/acf_control_chk.sv
// Assertion checker for the converter control block
`timescale 1ns/1ps
module acf_control_chk (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               sys_clk_en,
    input wire logic               mod_clk_en,
    input wire logic               data_ready,
    input wire acf_pkg::acf_path_t path_cfg,
    input wire logic [15:0]        osr_active,
    input wire logic               pins_blanked
);
    import acf_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [11:0] blank_cnt;
    logic [11:0] next_blank_cnt;
    always_comb next_blank_cnt = pins_blanked ? blank_cnt + 12'h001 : 12'h000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) blank_cnt <= 12'h000;
        else blank_cnt <= next_blank_cnt;
    end
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_ready_cause; pready |-> $past(psel) && $past(penable); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("pready without access phase");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
    property p_sys_pulse; sys_clk_en |=> !sys_clk_en; endproperty
    a_sys_pulse: assert property (p_sys_pulse) else $error("system tick too long");
    property p_mod_gap; mod_clk_en |=> !mod_clk_en [*8]; endproperty
    a_mod_gap: assert property (p_mod_gap) else $error("modulator ticks too close");
    property p_mod_sys; mod_clk_en |-> sys_clk_en; endproperty
    a_mod_sys: assert property (p_mod_sys) else $error("modulator tick off system tick");
    property p_wb_osr; !path_cfg.low_latency |-> osr_active[2:0] == 3'h0; endproperty
    a_wb_osr: assert property (p_wb_osr) else $error("wideband ratio not a multiple of 8");
    property p_blank_len; $fell(pins_blanked) |->
        blank_cnt >= BLANK_CYCLES - 12'h001 && blank_cnt <= BLANK_CYCLES + 12'h001;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("pin blanking length wrong");
    property p_dr_pulse; data_ready |=> !data_ready [*8]; endproperty
    a_dr_pulse: assert property (p_dr_pulse) else $error("results too close together");
    c_result: cover property (data_ready);
    c_blank_end: cover property ($fell(pins_blanked));
    c_slverr: cover property (pslverr);
endmodule : acf_control_chk
bind acf_control acf_control_chk i_acf_control_chk (.pclk, .presetn, .psel, .penable, .prdata,
    .pready, .pslverr, .sys_clk_en, .mod_clk_en, .data_ready, .path_cfg, .osr_active,
    .pins_blanked);

//--- tb/test_acf_control.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module test_acf_control;
    import acf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, start_pin, reset_n_pin, mod_saturated, ext_run;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, ext_clk_pin, int_osc_clk, sys_clk_en, mod_clk_en, data_ready;
    logic wide_input_range, pins_blanked;
    acf_path_t path_cfg;
    logic [15:0] osr_active;
    int n_errors = 0;
    int checked = 0;
    acf_control i_acf_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_clk_pin, .int_osc_clk, .start_pin, .reset_n_pin,
        .mod_saturated, .sys_clk_en, .mod_clk_en, .data_ready, .wide_input_range, .path_cfg,
        .osr_active, .pins_blanked);
    acf_clk_src i_acf_clk_src (.ext_run, .ext_clk_pin, .int_osc_clk);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic near(input int seen, input int exp, input string what);
        check({31'h0, seen >= exp - 1 && seen <= exp + 1}, 32'h0000_0001, what);
    endtask : near
    // Registered outputs read at an edge give their value from before it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) n_errors++;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask : rd
    task automatic count(input int cyc, output int s, output int m, output int d);
        s = 0; m = 0; d = 0;
        repeat (cyc) begin @(posedge pclk); s += sys_clk_en; m += mod_clk_en; d += data_ready; end
    endtask : count
    task automatic wait_dr(output int n);
        n = 0;
        do begin @(posedge pclk); n++; end while (data_ready !== 1'b1 && n < 3000);
        if (n >= 3000) n_errors++;
    endtask : wait_dr
    task give_verdict;
        if (n_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        give_verdict;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        int s, m, d, n;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
        start_pin = 0; reset_n_pin = 1; mod_saturated = 0; ext_run = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CONFIG_THREE, r); check(r, 32'h0000_0000, "clock config");
        rd(ADDR_FILTER_CFG, r); check(r, 32'(RST_FILTER_CFG), "filter config");
        check(32'(osr_active), 32'h0000_0020, "reset ratio");
        apb(1'b0, 8'h18, 32'h0, r, e); check({31'h0, e}, 32'h0000_0001, "unmapped error");
        wr(ADDR_CONFIG_ONE, 32'h0000_0001); repeat (2) @(posedge pclk);
        check({31'h0, wide_input_range}, 32'h0000_0001, "wide range");
        wr(ADDR_CONFIG_ONE, 32'h0000_0003); repeat (2) @(posedge pclk);
        check({31'h0, wide_input_range}, 32'h0000_0000, "forced 1x");
        rd(ADDR_STATUS_ONE, r); check(r & 32'h2, 32'h0000_0000, "status range");
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_FILTER_CFG, 32'(c << 1 | (c != 0) << 4 | c / 2 << 5 | 1 << 9) |
               (c == 3 ? 32'h1c0 : 32'h0));
            repeat (2) @(posedge pclk);
            check(32'(osr_active), 32'((4 << c) * 2 * ((c != 0) + 1) * (c / 2 + 1)), "wb ratio");
            if (c == 3) check(32'(path_cfg), 32'h0000_001f, "path");
            wr(ADDR_FILTER_CFG, 32'(c << 1 | 1 | 1 << 9));
            repeat (2) @(posedge pclk);
            check(32'(osr_active), 32'(12 << c), "ll ratio");
        end
        wr(ADDR_FILTER_CFG, 32'h0000_0200); repeat (2) @(posedge pclk);
        check(32'(osr_active), 32'h0000_0008, "first_fir_stage only ratio");
        count(400, s, m, d); near(s, 40, "int sys ticks"); near(m, 20, "int mod ticks");
        ext_run <= 1'b1;
        repeat (20) @(posedge pclk);
        wr(ADDR_CONFIG_THREE, 32'h0000_0003);
        start_pin <= 1'b1;
        rd(ADDR_CONFIG_THREE, r); check(r, 32'h0000_0003, "ext select");
        check({31'h0, pins_blanked}, 32'h0000_0001, "blanked");
        count(640, s, m, d); near(s, 40, "ext sys ticks"); near(m, 20, "ext mod ticks");
        check(32'(d), 32'h0000_0000, "start ignored");
        wait_dr(n);
        mod_saturated <= 1'b1;
        @(posedge pclk);
        mod_saturated <= 1'b0;
        wait_dr(n); near(n + 1, 256, "conversion period");
        rd(ADDR_STATUS_ONE, r); check(r & 32'h1, 32'h0000_0001, "saturation seen");
        wait_dr(n);
        rd(ADDR_STATUS_ONE, r); check(r & 32'h1, 32'h0000_0000, "saturation clear");
        wr(ADDR_CONFIG_THREE, 32'h0000_0000);
        repeat (40) @(posedge pclk);
        ext_run <= 1'b0;
        check({31'h0, pins_blanked}, 32'h0000_0001, "blanked again");
        reset_n_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(ADDR_CONFIG_ONE, r); check(r, 32'h0000_0003, "reset pin ignored");
        repeat (BLANK_CYCLES) @(posedge pclk);
        rd(ADDR_CONFIG_ONE, r); check(r, 32'(RST_CONFIG_ONE), "reset pin honoured");
        give_verdict;
    end
endmodule : test_acf_control
